// >>> verilog/bcs_supervisor.sv
// Breaker close supervisor with AXI4-Lite settings and status
// Behaviour
// - Attempt time limit 0 to 1200 s, default 0; zero disables timeout supervision.
// - Attempt timing starts once generator voltage is live and sync is active.
// - No breaker feedback before attempt time ends raises the timeout alarm.
// - On attempt expiry report selectable action code 1 to 5, default 2.
// - Dead-bus closing enabled by default closes onto dead bus when genset ready.
// - Dead-bus closing disabled never closes while bus is dead.
// - Close relay held at most hold time, 0.0 to 5.0 s, default 1.0.
// - No feedback within hold time counts the attempt as failed.
// - Relay drops on feedback, hold expiry, phase, slip or matched voltage leaving window.
// - Slip mode closes early by breaker mechanical lag, default 0.10 s.
// - Bias rate is rate times gain factor raised to unit count.
// - Multi-unit bus scales proportional gain by factor 0.8 to 1.0.
// - Voltage change rate scaled by voltage gain 0.1 to 10.0, default 1.0.
// - Trial mode runs check mode and suppresses every close command.
// - Phase offset of -60 to 60 degrees added to measured phase error.
// - Check mode matches and reports status but never closes the breaker.
// - Close attempts 1 to 20, default 3; exhausted gives fail alarm and auto-off.
// - Feedback held one reclose delay is success; opening within it is failure.
`timescale 1ns/10ps
`include "bcs_consts.svh"
module bcs_supervisor import bcs_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `BCS_TICK_NS / `BCS_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Breaker auxiliary contact pin
  input wire logic breaker_closed_feedback,
  // Measurements from same-clock logic
  input wire logic gen_voltage_live,
  input wire logic bus_dead,
  input wire logic genset_ready,
  input wire logic slip_in_window,
  input wire logic volt_in_window,
  input wire logic [7:0] phase_error,
  input wire logic [15:0] time_to_align,
  // Breaker and alarm outputs
  output logic close_relay_q,
  output logic timeout_alarm_q,
  output logic fail_alarm_q,
  output logic auto_off_q,
  output logic check_mode_q,
  output logic [2:0] attempt_expiry_action_q,
  // Control loop scaling outputs
  output logic [8:0] phase_corrected_q,
  output logic [6:0] prop_gain_scale_q,
  output logic [6:0] volt_rate_gain_q,
  output logic [31:0] bias_rate_q
);
  bcs_word_t cfg_q [0:`BCS_NCFG-1];
  bcs_word_t cfg_d [0:`BCS_NCFG-1];
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [3:0] widx, ridx;
  bcs_state_t state_q, state_d;
  logic [21:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  logic [16:0] tmr_q, tmr_d;
  logic [6:0] att_sub_q, att_sub_d;
  logic [10:0] att_sec_q, att_sec_d;
  logic att_run_q, att_run_d, fb_seen_q, fb_seen_d;
  logic [4:0] used_q, used_d;
  logic relay_d, tout_d, fail_d, aoff_d, check_d;
  logic [2:0] act_d;
  logic [8:0] corr_d;
  logic [6:0] pgain_d, vgain_d;
  logic fb_s1_q, fb_s2_q;
  logic sync_act, dead_en, trial, vmatch, slip_mode, fail_en;
  logic [8:0] corr_abs;
  logic phase_ok, win_ok, lag_ok, permit, fail_now;
  logic [16:0] hold_ticks, reclose_ticks;
  logic [31:0] rate_res;

  assign sync_act = cfg_q[`BCS_IDX_CTRL][`BCS_CTRL_ACT];
  assign dead_en = cfg_q[`BCS_IDX_CTRL][`BCS_CTRL_DEAD_EN];
  assign trial = cfg_q[`BCS_IDX_CTRL][`BCS_CTRL_TRIAL];
  assign vmatch = cfg_q[`BCS_IDX_CTRL][`BCS_CTRL_VMATCH];
  assign slip_mode = cfg_q[`BCS_IDX_CTRL][`BCS_CTRL_SLIP];
  assign fail_en = cfg_q[`BCS_IDX_CTRL][`BCS_CTRL_FAIL_EN];
  assign widx = aw_addr_q[5:2];
  assign ridx = s_axi_araddr[5:2];

  // Register bus: write path, read path and settings
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid & ~s_axi_bready;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid & ~s_axi_rready;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    for (int i = 0; i < `BCS_NCFG; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (s_axi_awvalid & s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_have_q & w_have_q & ~s_axi_bvalid) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `BCS_RESP_SLVERR;
      if (aw_addr_q[7:6] == 2'h0 && widx < `BCS_IDX_STATUS) begin
        bresp_d = `BCS_RESP_OKAY;
        for (int b = 0; b < 2; b++) begin
          if (wstrb_q[b]) begin
            cfg_d[widx][b*8 +: 8] = wdata_q[b*8 +: 8];
          end
        end
      end
    end
    if (s_axi_arvalid & s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `BCS_RESP_OKAY;
      rdata_d = 32'h00000000;
      if (s_axi_araddr[7:6] != 2'h0) begin
        rresp_d = `BCS_RESP_SLVERR;
      end else if (ridx < `BCS_IDX_STATUS) begin
        rdata_d = {16'h0000, cfg_q[ridx]};
      end else if (ridx == `BCS_IDX_STATUS) begin
        rdata_d = {16'h0000, attempt_expiry_action_q, used_q, check_mode_q, auto_off_q,
                   fail_alarm_q, timeout_alarm_q, close_relay_q, state_q};
      end else if (ridx == `BCS_IDX_RATE) begin
        rdata_d = bias_rate_q;
      end else begin
        rdata_d = {9'h000, volt_rate_gain_q, prop_gain_scale_q, phase_corrected_q};
      end
    end
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d = ~w_have_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q[`BCS_IDX_CTRL] <= `BCS_RST_CTRL;
      cfg_q[`BCS_IDX_LIMIT] <= `BCS_RST_LIMIT;
      cfg_q[`BCS_IDX_ACTION] <= `BCS_RST_ACTION;
      cfg_q[`BCS_IDX_HOLD] <= `BCS_RST_HOLD;
      cfg_q[`BCS_IDX_LAG] <= `BCS_RST_LAG;
      cfg_q[`BCS_IDX_RECLOSE] <= `BCS_RST_RECLOSE;
      cfg_q[`BCS_IDX_ATTEMPTS] <= `BCS_RST_ATTEMPTS;
      cfg_q[`BCS_IDX_BUSRATE] <= `BCS_RST_BUSRATE;
      cfg_q[`BCS_IDX_GAINF] <= `BCS_RST_GAINF;
      cfg_q[`BCS_IDX_VGAIN] <= `BCS_RST_VGAIN;
      cfg_q[`BCS_IDX_POFFSET] <= `BCS_RST_POFFSET;
      cfg_q[`BCS_IDX_PWIN] <= `BCS_RST_PWIN;
      cfg_q[`BCS_IDX_UNITS] <= `BCS_RST_UNITS;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      for (int i = 0; i < `BCS_NCFG; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
    end
  end

  // Sequencer: tick, attempt timer, close attempts
  always_comb begin
    corr_d = 9'({phase_error[7], phase_error} + {cfg_q[`BCS_IDX_POFFSET][7],
                cfg_q[`BCS_IDX_POFFSET][7:0]});
    corr_abs = corr_d[8] ? 9'(-corr_d) : corr_d;
    phase_ok = corr_abs <= {4'h0, cfg_q[`BCS_IDX_PWIN][4:0]};
    win_ok = phase_ok & slip_in_window & (volt_in_window | ~vmatch);
    lag_ok = ~slip_mode | (time_to_align <= {8'h00, cfg_q[`BCS_IDX_LAG][7:0]});
    hold_ticks = 17'({11'h000, cfg_q[`BCS_IDX_HOLD][5:0]} * `BCS_TICKS_PER_HOLD);
    reclose_ticks = 17'({6'h00, cfg_q[`BCS_IDX_RECLOSE][10:0]} * `BCS_TICKS_PER_SEC);
    permit = genset_ready & ~trial & (hold_ticks != 17'h00000) &
             (bus_dead ? dead_en : (win_ok & lag_ok));
    pgain_d = (cfg_q[`BCS_IDX_UNITS][4:0] > 5'h01) ? cfg_q[`BCS_IDX_GAINF][6:0]
              : `BCS_GAIN_UNITY;
    vgain_d = cfg_q[`BCS_IDX_VGAIN][6:0];
    tick_d = (tick_cnt_q == 22'(TICK_CYCLES - 1));
    tick_cnt_d = tick_d ? 22'h000000 : tick_cnt_q + 22'h000001;
    state_d = state_q;
    tmr_d = (tick_q && tmr_q != 17'h1FFFF) ? tmr_q + 17'h00001 : tmr_q;
    att_run_d = att_run_q | (sync_act & gen_voltage_live);
    att_sub_d = att_sub_q;
    att_sec_d = att_sec_q;
    if (att_run_q && tick_q && state_q != BCS_DONE) begin
      att_sub_d = att_sub_q + 7'h01;
      if (17'(att_sub_d) >= `BCS_TICKS_PER_SEC) begin
        att_sub_d = 7'h00;
        att_sec_d = (att_sec_q == 11'h7FF) ? att_sec_q : att_sec_q + 11'h001;
      end
    end
    fb_seen_d = fb_seen_q | (fb_s2_q & sync_act);
    used_d = used_q;
    tout_d = timeout_alarm_q;
    act_d = attempt_expiry_action_q;
    fail_d = fail_alarm_q;
    aoff_d = auto_off_q;
    relay_d = 1'b0;
    check_d = trial & sync_act;
    fail_now = 1'b0;
    if (cfg_q[`BCS_IDX_LIMIT][10:0] != 11'h000 && att_run_q && !fb_seen_q &&
        att_sec_q >= cfg_q[`BCS_IDX_LIMIT][10:0] && !timeout_alarm_q) begin
      tout_d = 1'b1;
      act_d = cfg_q[`BCS_IDX_ACTION][2:0];
    end
    case (state_q)
      BCS_IDLE: begin
        if (sync_act) begin
          state_d = BCS_ARMED;
        end
      end
      BCS_ARMED: begin
        if (permit) begin
          state_d = BCS_CLOSING;
          relay_d = 1'b1;
        end
      end
      BCS_CLOSING: begin
        if (fb_s2_q) begin
          state_d = BCS_VERIFY;
        end else if (tmr_q >= hold_ticks || trial || (bus_dead && !dead_en) ||
                     (!bus_dead && !win_ok)) begin
          fail_now = 1'b1;
        end else begin
          relay_d = 1'b1;
        end
      end
      BCS_VERIFY: begin
        if (!fb_s2_q) begin
          fail_now = 1'b1;
        end else if (tmr_q >= reclose_ticks) begin
          state_d = BCS_DONE;
        end
      end
      BCS_RECLOSE: begin
        if (tmr_q >= reclose_ticks) begin
          state_d = BCS_ARMED;
        end
      end
      default: begin
      end
    endcase
    if (fail_now) begin
      used_d = used_q + 5'h01;
      if (used_d >= cfg_q[`BCS_IDX_ATTEMPTS][4:0]) begin
        state_d = BCS_AUTO_OFF;
        aoff_d = 1'b1;
        fail_d = fail_en;
      end else begin
        state_d = BCS_RECLOSE;
      end
    end
    if (state_d != state_q) begin
      tmr_d = 17'h00000;
    end
    if (!sync_act) begin
      state_d = BCS_IDLE;
      relay_d = 1'b0;
      tout_d = 1'b0;
      fail_d = 1'b0;
      aoff_d = 1'b0;
      act_d = 3'h0;
      used_d = 5'h00;
      att_run_d = 1'b0;
      att_sub_d = 7'h00;
      att_sec_d = 11'h000;
      fb_seen_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fb_s1_q <= 1'b0;
      fb_s2_q <= 1'b0;
      state_q <= BCS_IDLE;
      tick_cnt_q <= 22'h000000;
      tick_q <= 1'b0;
      tmr_q <= 17'h00000;
      att_run_q <= 1'b0;
      att_sub_q <= 7'h00;
      att_sec_q <= 11'h000;
      fb_seen_q <= 1'b0;
      used_q <= 5'h00;
      close_relay_q <= 1'b0;
      timeout_alarm_q <= 1'b0;
      fail_alarm_q <= 1'b0;
      auto_off_q <= 1'b0;
      check_mode_q <= 1'b0;
      attempt_expiry_action_q <= 3'h0;
      phase_corrected_q <= 9'h000;
      prop_gain_scale_q <= 7'h00;
      volt_rate_gain_q <= 7'h00;
    end else begin
      fb_s1_q <= breaker_closed_feedback;
      fb_s2_q <= fb_s1_q;
      state_q <= state_d;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      tmr_q <= tmr_d;
      att_run_q <= att_run_d;
      att_sub_q <= att_sub_d;
      att_sec_q <= att_sec_d;
      fb_seen_q <= fb_seen_d;
      used_q <= used_d;
      close_relay_q <= relay_d;
      timeout_alarm_q <= tout_d;
      fail_alarm_q <= fail_d;
      auto_off_q <= aoff_d;
      check_mode_q <= check_d;
      attempt_expiry_action_q <= act_d;
      phase_corrected_q <= corr_d;
      prop_gain_scale_q <= pgain_d;
      volt_rate_gain_q <= vgain_d;
    end
  end

  bcs_rate_calc u_rate (
    .clk(clk),
    .reset_n(reset_n),
    .rate(cfg_q[`BCS_IDX_BUSRATE][9:0]),
    .factor(cfg_q[`BCS_IDX_GAINF][6:0]),
    .units(cfg_q[`BCS_IDX_UNITS][4:0]),
    .result_q(rate_res)
  );
  assign bias_rate_q = rate_res;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_trial_no_close: assert property (trial |=> !close_relay_q)
    else $error("Close relay energized in trial mode");
  a_dead_bus_gate: assert property ($rose(close_relay_q) && $past(bus_dead) |->
    $past(dead_en)) else $error("Closed onto dead bus while disabled");
  a_fb_drops_relay: assert property (close_relay_q && fb_s2_q |=> !close_relay_q)
    else $error("Relay held after breaker feedback");
  a_hold_limit: assert property (close_relay_q |-> tmr_q <= hold_ticks)
    else $error("Relay held past hold time");
  a_timeout_off: assert property (cfg_q[`BCS_IDX_LIMIT][10:0] == 11'h000 &&
    !timeout_alarm_q |=> !timeout_alarm_q) else $error("Timeout raised with limit zero");
  a_timeout_raise: assert property (sync_act && att_run_q && !fb_seen_q &&
    cfg_q[`BCS_IDX_LIMIT][10:0] != 11'h000 && att_sec_q >= cfg_q[`BCS_IDX_LIMIT][10:0]
    ##1 sync_act |-> timeout_alarm_q) else $error("Timeout alarm missing");
  a_auto_off_count: assert property ($rose(auto_off_q) |->
    used_q >= cfg_q[`BCS_IDX_ATTEMPTS][4:0]) else $error("Auto-off before attempts used");
  a_deact_clear: assert property (!sync_act |=> !timeout_alarm_q && !fail_alarm_q &&
    !close_relay_q && state_q == BCS_IDLE) else $error("Alarms kept after deactivation");
  a_verify_open: assert property (state_q == BCS_VERIFY && !fb_s2_q && sync_act |=>
    state_q inside {BCS_RECLOSE, BCS_AUTO_OFF}) else $error("Opened breaker not failed");
  a_lag_gate: assert property ($rose(close_relay_q) && $past(slip_mode && !bus_dead) |->
    $past(lag_ok)) else $error("Slip close before lag point");
  a_timer_armed: assert property (!att_run_q |-> att_sec_q == 11'h000 && att_sub_q == 7'h00)
    else $error("Attempt timer ran before arming");
endmodule : bcs_supervisor

// >>> verilog/bcs_consts.svh
// Constants for the breaker close supervisor
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
`define BCS_CLK_NS 5
`define BCS_TICK_NS 10000000
`define BCS_TICKS_PER_SEC 17'd100
`define BCS_TICKS_PER_HOLD 17'd10
`define BCS_NCFG 13
`define BCS_IDX_CTRL 4'h0
`define BCS_IDX_LIMIT 4'h1
`define BCS_IDX_ACTION 4'h2
`define BCS_IDX_HOLD 4'h3
`define BCS_IDX_LAG 4'h4
`define BCS_IDX_RECLOSE 4'h5
`define BCS_IDX_ATTEMPTS 4'h6
`define BCS_IDX_BUSRATE 4'h7
`define BCS_IDX_GAINF 4'h8
`define BCS_IDX_VGAIN 4'h9
`define BCS_IDX_POFFSET 4'hA
`define BCS_IDX_PWIN 4'hB
`define BCS_IDX_UNITS 4'hC
`define BCS_IDX_STATUS 4'hD
`define BCS_IDX_RATE 4'hE
`define BCS_IDX_GAINS 4'hF
`define BCS_CTRL_ACT 0
`define BCS_CTRL_DEAD_EN 1
`define BCS_CTRL_TRIAL 2
`define BCS_CTRL_VMATCH 3
`define BCS_CTRL_SLIP 4
`define BCS_CTRL_FAIL_EN 5
`define BCS_RST_CTRL 16'h002A
`define BCS_RST_LIMIT 16'h0000
`define BCS_RST_ACTION 16'h0002
`define BCS_RST_HOLD 16'h000A
`define BCS_RST_LAG 16'h000A
`define BCS_RST_RECLOSE 16'h0005
`define BCS_RST_ATTEMPTS 16'h0003
`define BCS_RST_BUSRATE 16'h0014
`define BCS_RST_GAINF 16'h0050
`define BCS_RST_VGAIN 16'h000A
`define BCS_RST_POFFSET 16'h0000
`define BCS_RST_PWIN 16'h000A
`define BCS_RST_UNITS 16'h0001
`define BCS_GAIN_UNITY 7'h64
`define BCS_Q16_ONE 32'h00010000
`define BCS_Q16_SCALE 34'h00010625
`define BCS_RESP_OKAY 2'h0
`define BCS_RESP_SLVERR 2'h2
`endif

// >>> verilog/bcs_pkg.sv
// Types for the breaker close supervisor
package bcs_pkg;
  typedef enum logic [2:0] {
    BCS_IDLE = 3'b000,
    BCS_ARMED = 3'b001,
    BCS_CLOSING = 3'b010,
    BCS_VERIFY = 3'b011,
    BCS_RECLOSE = 3'b100,
    BCS_DONE = 3'b101,
    BCS_AUTO_OFF = 3'b110
  } bcs_state_t;
  typedef logic [15:0] bcs_word_t;
endpackage : bcs_pkg

// >>> verilog/bcs_rate_calc.sv
// Bus matching bias rate: (rate times gain factor) raised to the unit count
`timescale 1ns/10ps
`include "bcs_consts.svh"
module bcs_rate_calc import bcs_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Settings: rate in 0.1 s, factor in 0.01, load-sharing unit count
  input wire logic [9:0] rate,
  input wire logic [6:0] factor,
  input wire logic [4:0] units,
  // Result in Q16.16, refreshed once per pass
  output logic [31:0] result_q
);
  logic [31:0] acc_q, acc_d, result_d;
  logic [4:0] cnt_q, cnt_d;
  logic [33:0] base;
  logic [63:0] prod;

  always_comb begin
    base = (34'(rate) * 34'(factor) * `BCS_Q16_SCALE) >> 10;
    prod = 64'(acc_q) * 64'(base);
    acc_d = acc_q;
    cnt_d = cnt_q;
    result_d = result_q;
    if (cnt_q >= units) begin
      result_d = acc_q;
      acc_d = `BCS_Q16_ONE;
      cnt_d = 5'h00;
    end else begin
      acc_d = (prod[63:48] != 16'h0000) ? 32'hFFFFFFFF : prod[47:16];
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= `BCS_Q16_ONE;
      cnt_q <= 5'h00;
      result_q <= 32'h00000000;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      result_q <= result_d;
    end
  end
endmodule : bcs_rate_calc

// >>> verification/bcs_breaker_model.sv
// Behavioural model of the generator breaker and its auxiliary contact
`timescale 1ns/10ps
module bcs_breaker_model #(
  parameter int LAG = 6
) (
  // Clock
  input wire logic clk,
  // Close relay driver and a stuck-open fault control
  input wire logic relay,
  input wire logic jammed,
  // Auxiliary contact, high when closed
  output logic closed
);
  int cnt;
  initial begin
    closed = 1'b0;
    cnt = 0;
  end
  // Contacts meet LAG+1 cycles after the coil is energized and then stay shut
  always @(posedge clk) begin
    if (jammed) begin
      closed <= 1'b0;
      cnt <= 0;
    end else if (relay && !closed) begin
      cnt <= cnt + 1;
      if (cnt >= LAG) begin
        closed <= 1'b1;
      end
    end
  end
endmodule : bcs_breaker_model

// >>> verification/testbench.sv
// Self-checking bench for the breaker close supervisor
`timescale 1ns/10ps
module testbench;
  import bcs_pkg::*;
  logic clk, reset_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, phase_error;
  logic [31:0] s_axi_wdata, s_axi_rdata, bias_rate_q, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic breaker_closed_feedback, gen_voltage_live, bus_dead, genset_ready;
  logic slip_in_window, volt_in_window, jammed, relay_seen;
  logic [15:0] time_to_align;
  logic close_relay_q, timeout_alarm_q, fail_alarm_q, auto_off_q, check_mode_q;
  logic [2:0] attempt_expiry_action_q;
  logic [8:0] phase_corrected_q;
  logic [6:0] prop_gain_scale_q, volt_rate_gain_q;
  int n_errors, n_checks, cyc, dur;

  bcs_supervisor #(.TICK_CYCLES(4)) bcs_supervisor_inst (.*);
  bcs_breaker_model bcs_breaker_model_inst (.clk(clk), .relay(close_relay_q), .jammed(jammed),
    .closed(breaker_closed_feedback));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Write with address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : axr

  // Deactivate, then activate with the given control word
  task automatic arm(input logic [31:0] ctrl);
    axw(8'h00, 32'h0000002A);
    relay_seen = 1'b0;
    axw(8'h00, ctrl);
  endtask : arm

  task automatic wait_relay;
    while (close_relay_q !== 1'b1) @(posedge clk);
    dur = 0;
    while (close_relay_q === 1'b1) begin
      @(posedge clk);
      dur++;
    end
  endtask : wait_relay

  task automatic t_regs;
    logic [7:0] ad [6];
    logic [15:0] ex [6];
    ad = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
    ex = '{16'h002A, 16'h0000, 16'h0002, 16'h000A, 16'h0003, 16'h0001};
    foreach (ad[i]) begin
      axr(ad[i]);
      chk(rd, {16'h0000, ex[i]});
    end
    axw(8'h34, 32'h00001234);
    chk(rsp, 2'h2);
    axr(8'h40);
    chk(rsp, 2'h2);
  endtask : t_regs

  task automatic t_trial;
    bus_dead <= 1'b1;
    arm(32'h0000002F);
    repeat (200) @(posedge clk);
    chk(relay_seen, 1'b0);
    chk(check_mode_q, 1'b1);
  endtask : t_trial

  task automatic t_dead;
    arm(32'h00000029);
    repeat (200) @(posedge clk);
    chk(relay_seen, 1'b0);
    arm(32'h0000002B);
    wait_relay();
    chk(breaker_closed_feedback, 1'b1);
    chk(dur <= 12, 1'b1);
  endtask : t_dead

  task automatic t_exhaust;
    jammed <= 1'b1;
    bus_dead <= 1'b0;
    axw(8'h0C, 32'h1);
    axw(8'h18, 32'h1);
    axw(8'h14, 32'h1);
    axr(8'h34);
    chk(rd, 32'h00000104);
    arm(32'h0000002B);
    wait_relay();
    chk(dur >= 36 && dur <= 42, 1'b1);
    while (auto_off_q !== 1'b1) @(posedge clk);
    chk(fail_alarm_q, 1'b1);
    chk(timeout_alarm_q, 1'b0);
  endtask : t_exhaust

  task automatic t_window;
    axw(8'h0C, 32'h5);
    axw(8'h18, 32'h3);
    arm(32'h0000002B);
    while (close_relay_q !== 1'b1) @(posedge clk);
    repeat (5) @(posedge clk);
    slip_in_window <= 1'b0;
    repeat (3) @(posedge clk);
    chk(close_relay_q, 1'b0);
    slip_in_window <= 1'b1;
  endtask : t_window

  task automatic t_slip;
    time_to_align <= 16'h0032;
    arm(32'h0000003B);
    repeat (100) @(posedge clk);
    chk(relay_seen, 1'b0);
    time_to_align <= 16'h000A;
    repeat (12) @(posedge clk);
    chk(relay_seen, 1'b1);
  endtask : t_slip

  task automatic t_timeout;
    axw(8'h04, 32'h2); // Limit longer than the reclose delay
    axw(8'h0C, 32'h1);
    axw(8'h18, 32'h14);
    gen_voltage_live <= 1'b0;
    arm(32'h0000002B);
    repeat (1000) @(posedge clk);
    chk(timeout_alarm_q, 1'b0);
    gen_voltage_live <= 1'b1;
    for (int code = 1; code <= 5; code++) begin
      axw(8'h08, code);
      arm(32'h0000002B);
      dur = 0;
      while (timeout_alarm_q !== 1'b1) begin
        @(posedge clk);
        dur++;
      end
      chk(dur >= 780 && dur <= 805, 1'b1);
      chk(attempt_expiry_action_q, code[2:0]);
    end
    axw(8'h00, 32'h0000002A);
    @(posedge clk);
    chk(timeout_alarm_q, 1'b0);
  endtask : t_timeout

  task automatic t_scale;
    phase_error <= 8'h14;
    axw(8'h28, 32'h000000FB);
    axw(8'h30, 32'h2);
    axw(8'h20, 32'h5A);
    axw(8'h24, 32'h25);
    repeat (4) @(posedge clk);
    chk(phase_corrected_q, 9'h00F);
    chk(prop_gain_scale_q, 7'h5A);
    chk(volt_rate_gain_q, 7'h25);
    axw(8'h20, 32'h64);
    axw(8'h30, 32'h3);
    repeat (10) @(posedge clk);
    chk(bias_rate_q, 32'h00080000);
  endtask : t_scale

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (close_relay_q === 1'b1) begin
      relay_seen <= 1'b1;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {gen_voltage_live, genset_ready, slip_in_window, volt_in_window} = 4'hF;
    {bus_dead, jammed, relay_seen} = 3'h0;
    phase_error = 8'h00;
    time_to_align = 16'h0032;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_trial();
    t_dead();
    t_exhaust();
    t_window();
    t_slip();
    t_timeout();
    t_scale();
    close_out();
  end
endmodule : testbench
